/* pia_pkg.sv */
// constants shared by the priority interrupt arbiter
// What this block does
// - accept 82 sources; programmable ones get one of three levels by register field, or 00 to disable
// - within one level the lowest active source number wins
// - signal the core when a request of sufficient priority is pending, with address
// - normal vector address is vector base concatenated with the winning vector number
// - report current level code: 00 none, 01 level 0, 10 level 1, 11 level 2/3
// - two fast interrupts, each a match register and low/high address pair
// - level-2 winner matching a fast match register uses that pair's address
// - fast decision is made here and presented with the vector for the fetch
// - in wait or stop, any pending request raises the wake line to the integration unit
// - only sources enabled before entering wait or stop can wake the core
// - in wait and stop, external request A is low-level sensitive regardless of mode
// - in stop, only the CAN source and external A and B can request
// - after reset the initial fetch address is driven onto the core address
// - all configuration and status registers are reached over the register bus
// - priority fields reset to 00 (disabled); 01/10/11 select levels 1/2/3
// - low-range sources map 01/10/11 to levels 0/1/2; 00 disables
// - reserved priority bits read zero and ignore writes
package pia_pkg;
	localparam int NUM_SRC = 82;
	localparam int FIXED_SRC = 2;
	localparam int NUM_PRIO_REGS = 10;
	localparam int FIELDS_PER_REG = 8;
	localparam int NUM_FIELDS = NUM_PRIO_REGS * FIELDS_PER_REG;
	localparam int NUM_PEND_REGS = 6;
	localparam int REG_W = 16;
	localparam int VEC_W = 7;
	localparam int VBA_W = 14;
	localparam int FVH_W = 5;
	localparam int ADDR_W = 21;
	localparam int IDX_W = 6;
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PRIO0 = 6'h00;
	localparam logic [IDX_W-1:0] IDX_VBASE = 6'h0a;
	localparam logic [IDX_W-1:0] IDX_FM0 = 6'h0b;
	localparam logic [IDX_W-1:0] IDX_FVL0 = 6'h0c;
	localparam logic [IDX_W-1:0] IDX_FVH0 = 6'h0d;
	localparam logic [IDX_W-1:0] IDX_FM1 = 6'h0e;
	localparam logic [IDX_W-1:0] IDX_FVL1 = 6'h0f;
	localparam logic [IDX_W-1:0] IDX_FVH1 = 6'h10;
	localparam logic [IDX_W-1:0] IDX_PEND0 = 6'h11;
	localparam logic [IDX_W-1:0] IDX_CTRL = 6'h1d;
	// control register fields
	localparam int CTRL_EDGE = 0;
	localparam int CTRL_CLR = 2;
	localparam int CTRL_LVL = 4;
	localparam int CTRL_PEND = 6;
	localparam int CTRL_INT = 8;
	localparam logic [1:0] CTRL_RW_MASK = 2'h3;
	// priority field and level codes
	localparam logic [1:0] FIELD_OFF = 2'h0;
	localparam logic [1:0] FIXED_LEVEL = 2'h3;
	localparam logic [1:0] FAST_LEVEL = 2'h2;
	localparam logic [1:0] CODE_NONE = 2'h0;
	localparam logic [1:0] CODE_L0 = 2'h1;
	localparam logic [1:0] CODE_L1 = 2'h2;
	localparam logic [1:0] CODE_HIGH = 2'h3;
	// reset values
	localparam logic [VBA_W-1:0] VBASE_RST = 14'h0000;
	localparam logic [VEC_W-1:0] FM_RST = 7'h00;
	localparam logic [REG_W-1:0] FVL_RST = 16'h0000;
	localparam logic [FVH_W-1:0] FVH_RST = 5'h00;
endpackage : pia_pkg

/* pia_level_encoder.sv */
// lowest-index priority encoder for one interrupt level
`timescale 1ns/100ps
module pia_level_encoder #(
	parameter int N = 82,
	parameter int W = 7
) (
	input wire logic [N-1:0] req,
	output logic valid,
	output logic [W-1:0] index
);
	always_comb begin
		valid = 1'b0;
		index = '0;
		// scan downward so the lowest active number is the last one written
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				valid = 1'b1;
				index = W'(i);
			end
		end
	end
endmodule : pia_level_encoder

/* pia_arbiter.sv */
// priority interrupt arbiter with avalon register slave
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
module pia_arbiter #(
	parameter logic [pia_pkg::ADDR_W-1:0] RESET_ADDR = 21'h000000,
	parameter int EXT_A_SRC = 8,
	parameter int EXT_B_SRC = 9,
	parameter int CAN_SRC = 10,
	parameter logic [pia_pkg::NUM_FIELDS-1:0] LOW_RANGE = 80'h0000_0000_0000_0000_ff00,
	parameter logic [pia_pkg::NUM_FIELDS-1:0] FIELD_IMPL = {80{1'b1}}
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [pia_pkg::NUM_SRC-1:0] irqSrc,
	input wire logic extReqAN,
	input wire logic extReqBN,
	input wire logic waitMode,
	input wire logic stopMode,
	input wire logic [1:0] coreMaskBits,
	output logic intRequest,
	output logic [1:0] currentLevelCode,
	output logic [pia_pkg::ADDR_W-1:0] vectorAddr,
	output logic fastInt,
	output logic initFetch,
	output logic wakeRequest
);
	localparam int NS = pia_pkg::NUM_SRC;
	localparam int VW = pia_pkg::VEC_W;

	if (EXT_A_SRC < pia_pkg::FIXED_SRC || EXT_A_SRC >= NS || EXT_B_SRC < pia_pkg::FIXED_SRC
		|| EXT_B_SRC >= NS || CAN_SRC >= NS || EXT_A_SRC == EXT_B_SRC) begin : g_bad
		$error("pia_arbiter: source numbers out of range");
	end

	// field value to {enable, level}
	function automatic logic [2:0] fieldLevel(input logic [1:0] f, input logic lowRange);
		logic [1:0] lvl;
		lvl = lowRange ? 2'(f - 2'h1) : f;
		return {f != pia_pkg::FIELD_OFF, lvl};
	endfunction : fieldLevel

	logic [pia_pkg::REG_W-1:0] prio_reg [pia_pkg::NUM_PRIO_REGS];
	logic [pia_pkg::VBA_W-1:0] vbase_reg;
	logic [VW-1:0] fm_reg [2];
	logic [pia_pkg::REG_W-1:0] fvl_reg [2];
	logic [pia_pkg::FVH_W-1:0] fvh_reg [2];
	logic [1:0] edgeMode_reg;
	logic [1:0] extPend_reg;
	logic [1:0] extSync1_reg;
	logic [1:0] extSync2_reg;
	logic [1:0] extPrev_reg;
	logic [NS-1:0] enSnap_reg;
	logic avs_waitrequest_next;
	logic intRequest_next;
	logic [1:0] currentLevelCode_next;
	logic [pia_pkg::ADDR_W-1:0] vectorAddr_next;
	logic fastInt_next;

	logic [NS-1:0] enNow;
	logic [NS-1:0] reqEff;
	logic [NS-1:0] active;
	logic [1:0] srcLevel [NS];
	logic [NS-1:0] lvlVec [4];
	logic [3:0] lvlValid;
	logic [VW-1:0] lvlIdx [4];
	logic winValid;
	logic [1:0] winLevel;
	logic [VW-1:0] winIdx;
	logic [1:0] fastHit;
	logic lowPower;
	logic [1:0] extReq;
	logic busWr;
	logic [pia_pkg::IDX_W-1:0] regIdx;

	assign lowPower = waitMode | stopMode;
	assign regIdx = avs_address[7:2];
	assign busWr = avs_write & ~avs_waitrequest & (avs_byteenable[1:0] == 2'h3);

	// external pins: two flops before any logic looks at them
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			extSync1_reg <= 2'h3;
			extSync2_reg <= 2'h3;
			extPrev_reg <= 2'h3;
		end else begin
			extSync1_reg <= {extReqBN, extReqAN};
			extSync2_reg <= extSync1_reg;
			extPrev_reg <= extSync2_reg;
		end
	end

	// edge latch: a new falling edge wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			extPend_reg <= 2'h0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				extPend_reg[k] <= (extPrev_reg[k] & ~extSync2_reg[k])
					| (extPend_reg[k] & ~(busWr && regIdx == pia_pkg::IDX_CTRL
					&& avs_writedata[pia_pkg::CTRL_CLR + k]));
			end
		end
	end

	// low power forces level sensing since no clock edges can be seen there
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			extReq[k] = (lowPower || !edgeMode_reg[k]) ? ~extSync2_reg[k] : extPend_reg[k];
		end
	end

	for (genvar s = 0; s < NS; s++) begin : g_src
		logic [2:0] decoded;
		logic raw;
		if (s < pia_pkg::FIXED_SRC) begin : g_fixed
			assign decoded = {1'b1, pia_pkg::FIXED_LEVEL};
		end else begin : g_prog
			localparam int F = s - pia_pkg::FIXED_SRC;
			assign decoded = fieldLevel(prio_reg[F / pia_pkg::FIELDS_PER_REG]
				[2 * (F % pia_pkg::FIELDS_PER_REG) +: 2], LOW_RANGE[F]);
		end
		if (s == EXT_A_SRC) begin : g_a
			assign raw = extReq[0];
		end else if (s == EXT_B_SRC) begin : g_b
			assign raw = extReq[1];
		end else begin : g_plain
			assign raw = irqSrc[s];
		end
		assign enNow[s] = decoded[2];
		assign srcLevel[s] = decoded[1:0];
		// clocked peripherals are silent in stop
		assign reqEff[s] = raw & (!stopMode || s == CAN_SRC || s == EXT_A_SRC
			|| s == EXT_B_SRC);
		assign active[s] = reqEff[s] & (lowPower ? enSnap_reg[s] : enNow[s]);
		for (genvar l = 0; l < 4; l++) begin : g_lvl
			assign lvlVec[l][s] = active[s] && srcLevel[s] == 2'(l);
		end
	end

	// the enable picture freezes on entry to wait or stop
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			enSnap_reg <= '0;
		end else if (!lowPower) begin
			enSnap_reg <= enNow;
		end
	end

	for (genvar l = 0; l < 4; l++) begin : g_enc
		pia_level_encoder #(.N(NS), .W(VW)) u_enc (
			.req(lvlVec[l]),
			.valid(lvlValid[l]),
			.index(lvlIdx[l])
		);
	end

	// highest level that the core mask still lets through
	always_comb begin
		winValid = 1'b0;
		winLevel = 2'h0;
		winIdx = '0;
		for (int l = 0; l < 4; l++) begin
			if (lvlValid[l] && 2'(l) >= coreMaskBits) begin
				winValid = 1'b1;
				winLevel = 2'(l);
				winIdx = lvlIdx[l];
			end
		end
		for (int k = 0; k < 2; k++) begin
			fastHit[k] = winValid && winLevel == pia_pkg::FAST_LEVEL && winIdx == fm_reg[k];
		end
	end

	always_comb begin
		intRequest_next = winValid;
		fastInt_next = |fastHit;
		case (winLevel)
			2'h0: currentLevelCode_next = pia_pkg::CODE_L0;
			2'h1: currentLevelCode_next = pia_pkg::CODE_L1;
			default: currentLevelCode_next = pia_pkg::CODE_HIGH;
		endcase
		if (!winValid) begin
			currentLevelCode_next = pia_pkg::CODE_NONE;
		end
		if (fastHit[0]) begin
			vectorAddr_next = {fvh_reg[0], fvl_reg[0]};
		end else if (fastHit[1]) begin
			vectorAddr_next = {fvh_reg[1], fvl_reg[1]};
		end else begin
			vectorAddr_next = {vbase_reg, winIdx};
		end
	end

	// outputs to the core are registered, so they lag the request by one clock
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			intRequest <= 1'b0;
			currentLevelCode <= pia_pkg::CODE_NONE;
			vectorAddr <= RESET_ADDR;
			fastInt <= 1'b0;
			initFetch <= 1'b1;
		end else begin
			initFetch <= 1'b0;
			intRequest <= intRequest_next;
			currentLevelCode <= currentLevelCode_next;
			vectorAddr <= vectorAddr_next;
			fastInt <= fastInt_next;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wakeRequest <= 1'b0;
		end else begin
			wakeRequest <= lowPower && |active;
		end
	end

	// one wait state: waitrequest idles high and drops for the cycle the access completes
	assign avs_waitrequest_next = !((avs_read || avs_write) && avs_waitrequest);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= avs_waitrequest_next;
		end
	end

	// writes take effect on the completing edge; lanes 0 and 1 hold the 16-bit registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int r = 0; r < pia_pkg::NUM_PRIO_REGS; r++) begin
				prio_reg[r] <= '0;
			end
			vbase_reg <= pia_pkg::VBASE_RST;
			fm_reg[0] <= pia_pkg::FM_RST;
			fm_reg[1] <= pia_pkg::FM_RST;
			fvl_reg[0] <= pia_pkg::FVL_RST;
			fvl_reg[1] <= pia_pkg::FVL_RST;
			fvh_reg[0] <= pia_pkg::FVH_RST;
			fvh_reg[1] <= pia_pkg::FVH_RST;
			edgeMode_reg <= 2'h0;
		end else if (busWr && avs_byteenable[1:0] == 2'h3) begin
			for (int r = 0; r < pia_pkg::NUM_PRIO_REGS; r++) begin
				if (regIdx == pia_pkg::IDX_PRIO0 + 6'(r)) begin
					for (int j = 0; j < pia_pkg::FIELDS_PER_REG; j++) begin
						if (FIELD_IMPL[r * pia_pkg::FIELDS_PER_REG + j]) begin
							prio_reg[r][2*j +: 2] <= avs_writedata[2*j +: 2];
						end
					end
				end
			end
			case (regIdx)
				pia_pkg::IDX_VBASE: vbase_reg <= avs_writedata[pia_pkg::VBA_W-1:0];
				pia_pkg::IDX_FM0: fm_reg[0] <= avs_writedata[VW-1:0];
				pia_pkg::IDX_FVL0: fvl_reg[0] <= avs_writedata[pia_pkg::REG_W-1:0];
				pia_pkg::IDX_FVH0: fvh_reg[0] <= avs_writedata[pia_pkg::FVH_W-1:0];
				pia_pkg::IDX_FM1: fm_reg[1] <= avs_writedata[VW-1:0];
				pia_pkg::IDX_FVL1: fvl_reg[1] <= avs_writedata[pia_pkg::REG_W-1:0];
				pia_pkg::IDX_FVH1: fvh_reg[1] <= avs_writedata[pia_pkg::FVH_W-1:0];
				pia_pkg::IDX_CTRL: edgeMode_reg <= avs_writedata[pia_pkg::CTRL_EDGE +: 2];
				default: ;
			endcase
		end
	end

	// read data is captured on the first cycle, while waitrequest is still high
	logic [pia_pkg::NUM_PEND_REGS*pia_pkg::REG_W-1:0] pendFlat;
	logic [31:0] rdMux;
	assign pendFlat = {{(pia_pkg::NUM_PEND_REGS * pia_pkg::REG_W - NS){1'b0}}, active};
	always_comb begin
		rdMux = 32'h0000_0000;
		if (regIdx < pia_pkg::IDX_PRIO0 + 6'(pia_pkg::NUM_PRIO_REGS)) begin
			rdMux[15:0] = prio_reg[4'(regIdx)];
		end else if (regIdx >= pia_pkg::IDX_PEND0
			&& regIdx < pia_pkg::IDX_PEND0 + 6'(pia_pkg::NUM_PEND_REGS)) begin
			rdMux[15:0] = pendFlat[16 * 32'(regIdx - pia_pkg::IDX_PEND0) +: 16];
		end else begin
			case (regIdx)
				pia_pkg::IDX_VBASE: rdMux[pia_pkg::VBA_W-1:0] = vbase_reg;
				pia_pkg::IDX_FM0: rdMux[VW-1:0] = fm_reg[0];
				pia_pkg::IDX_FVL0: rdMux[15:0] = fvl_reg[0];
				pia_pkg::IDX_FVH0: rdMux[pia_pkg::FVH_W-1:0] = fvh_reg[0];
				pia_pkg::IDX_FM1: rdMux[VW-1:0] = fm_reg[1];
				pia_pkg::IDX_FVL1: rdMux[15:0] = fvl_reg[1];
				pia_pkg::IDX_FVH1: rdMux[pia_pkg::FVH_W-1:0] = fvh_reg[1];
				pia_pkg::IDX_CTRL: begin
					rdMux[pia_pkg::CTRL_EDGE +: 2] = edgeMode_reg;
					rdMux[pia_pkg::CTRL_LVL +: 2] = currentLevelCode;
					rdMux[pia_pkg::CTRL_PEND +: 2] = extPend_reg;
					rdMux[pia_pkg::CTRL_INT] = intRequest;
				end
				default: ;
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rdMux;
		end
	end

	bus_wait_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access not completed after one wait state");
	mask_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		intRequest |-> $past(winLevel) >= $past(coreMaskBits))
		else $error("request raised below core mask");
	base_concat_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		intRequest && !fastInt |-> vectorAddr == {$past(vbase_reg), $past(winIdx)})
		else $error("normal vector is not base and vector number");
	fast_addr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		fastHit[0] |=> fastInt && vectorAddr == {$past(fvh_reg[0]), $past(fvl_reg[0])})
		else $error("fast match zero address not used");
	no_fast_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		winValid && winLevel != pia_pkg::FAST_LEVEL |=> !fastInt)
		else $error("fast flag raised for a level other than two");
	lowest_wins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		winValid |-> lvlVec[winLevel][winIdx] && (lvlVec[winLevel] & ((82'h1 << winIdx) - 82'h1)) == '0)
		else $error("winner is not the lowest active source");
	level_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!intRequest |-> currentLevelCode == pia_pkg::CODE_NONE)
		else $error("level code reported without a request");
	wake_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		lowPower && |active |=> wakeRequest)
		else $error("pending request in low power did not wake");
	stop_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		stopMode && irqSrc[CAN_SRC] == 1'b0 && extSync2_reg == 2'h3 |-> !(|active))
		else $error("source active in stop without a wake source");
	init_fetch_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		initFetch |-> vectorAddr == RESET_ADDR ##1 !initFetch)
		else $error("initial fetch address not presented after reset");
endmodule : pia_arbiter

/* pia_core_model.sv */
// core and integration unit model on the far side of the arbiter
`timescale 1ns/100ps
module pia_core_model (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [1:0] maskSet,
	input wire logic goWait,
	input wire logic goStop,
	input wire logic jsrFetched,
	input wire logic intRequest,
	input wire logic fastInt,
	input wire logic wakeRequest,
	output logic [1:0] coreMaskBits,
	output logic waitMode,
	output logic stopMode,
	output logic fastHandling
);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			coreMaskBits <= 2'h0;
			waitMode <= 1'b0;
			stopMode <= 1'b0;
			fastHandling <= 1'b0;
		end else begin
			coreMaskBits <= maskSet;
			// entry is a one-cycle command; clocks restart only on the wake line
			waitMode <= goWait | (waitMode & ~wakeRequest);
			stopMode <= goStop | (stopMode & ~wakeRequest);
			fastHandling <= intRequest & fastInt & ~jsrFetched;
		end
	end
endmodule : pia_core_model

/* pia_arbiter_bench.sv */
// self-checking bench for the priority interrupt arbiter
`timescale 1ns/100ps
module pia_arbiter_bench;
	localparam logic [20:0] RST_ADDR = 21'h01a2b3;
	// top field left reserved so its read-zero behaviour is exercised
	localparam logic [79:0] IMPL = {1'b0, {79{1'b1}}};
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [81:0] irqSrc = 82'h0;
	logic extReqAN = 1'b1;
	logic extReqBN = 1'b1;
	logic [1:0] maskSet = 2'h0;
	logic goWait = 1'b0;
	logic goStop = 1'b0;
	logic jsrFetched = 1'b0;
	logic waitMode, stopMode, intRequest, fastInt, initFetch, wakeRequest, fastHandling;
	logic [1:0] coreMaskBits, currentLevelCode;
	logic [20:0] vectorAddr;
	int checks = 0;
	int miscompares = 0;
	int fld[80] = '{default: 0};
	int fm0 = 0;
	int fm1 = 0;
	logic [13:0] vb = 14'h0000;
	logic [20:0] fa0 = 21'h0;
	logic [20:0] fa1 = 21'h0;
	logic expReq, expFast;
	logic [1:0] expCode;
	logic [20:0] expVec;
	logic [15:0] lfsr = 16'h1860;
	logic [31:0] q;

	pia_arbiter #(.RESET_ADDR(RST_ADDR), .FIELD_IMPL(IMPL)) i_dut (.sys_clk(sys_clk),
		.resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irqSrc(irqSrc), .extReqAN(extReqAN),
		.extReqBN(extReqBN), .waitMode(waitMode), .stopMode(stopMode),
		.coreMaskBits(coreMaskBits), .intRequest(intRequest),
		.currentLevelCode(currentLevelCode), .vectorAddr(vectorAddr), .fastInt(fastInt),
		.initFetch(initFetch), .wakeRequest(wakeRequest));
	pia_core_model i_core (.sys_clk(sys_clk), .resetn(resetn), .maskSet(maskSet),
		.goWait(goWait), .goStop(goStop), .jsrFetched(jsrFetched), .intRequest(intRequest),
		.fastInt(fastInt), .wakeRequest(wakeRequest), .coreMaskBits(coreMaskBits),
		.waitMode(waitMode), .stopMode(stopMode), .fastHandling(fastHandling));

	always #5 sys_clk = ~sys_clk;

	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (checks > 0 && miscompares == 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [15:0] rnd16();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd16

	function automatic logic [15:0] regVal(input int r);
		logic [15:0] d;
		for (int j = 0; j < 8; j++) d[2*j+:2] = 2'(fld[r*8+j]);
		return d;
	endfunction : regVal

	task automatic bus(input logic wr, input int idx, input logic [15:0] d,
		input logic [3:0] be, output logic [31:0] rd);
		int n;
		@(posedge sys_clk);
		avs_address <= 8'(idx * 4);
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) miscompares++;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (wr && be[1:0] == 2'h3) begin
			for (int j = 0; j < 8; j++) if (idx < 10 && IMPL[idx*8+j]) fld[idx*8+j] = d[2*j+:2];
			case (idx)
				10: vb = d[13:0];
				11: fm0 = d[6:0];
				12: fa0[15:0] = d;
				13: fa0[20:16] = d[4:0];
				14: fm1 = d[6:0];
				15: fa1[15:0] = d;
				16: fa1[20:16] = d[4:0];
				default: ;
			endcase
		end
	endtask : bus

	task automatic setField(input int s, input int v);
		logic [31:0] dq;
		fld[s-2] = v;
		bus(1'b1, (s - 2) / 8, regVal((s - 2) / 8), 4'hf, dq);
	endtask : setField

	task automatic calcExp(input logic [81:0] s, input logic [1:0] m);
		int best;
		int win;
		int lv;
		best = -1;
		win = 0;
		for (int i = 0; i < 82; i++) begin
			if (i < 2) lv = 3;
			else if (fld[i-2] == 0) lv = -1;
			else if (i >= 10 && i <= 17) lv = fld[i-2] - 1;
			else lv = fld[i-2];
			if (s[i] && i != 8 && i != 9 && lv > best) begin
				best = lv;
				win = i;
			end
		end
		expReq = best >= int'(m);
		expCode = (best == 0) ? 2'h1 : (best == 1) ? 2'h2 : 2'h3;
		expFast = best == 2 && (win == fm0 || win == fm1);
		expVec = !expFast ? {vb, 7'(win)} : (win == fm0) ? fa0 : fa1;
	endtask : calcExp

	// mask reaches the arbiter through the core model, hence three edges
	task automatic apply(input logic [81:0] s, input logic [1:0] m);
		@(posedge sys_clk);
		irqSrc <= s;
		maskSet <= m;
		jsrFetched <= lfsr[0];
		repeat (3) @(posedge sys_clk);
		#1;
		calcExp(s, m);
		check(intRequest, expReq);
		check(fastHandling, expReq & expFast & ~jsrFetched);
		if (expReq) begin
			check(currentLevelCode, expCode);
			check(vectorAddr, expVec);
			check(fastInt, expFast);
		end else begin
			check(currentLevelCode, pia_pkg::CODE_NONE);
			check(fastInt, 1'b0);
		end
	endtask : apply

	task automatic enter(input logic stop);
		@(posedge sys_clk);
		goStop <= stop;
		goWait <= !stop;
		@(posedge sys_clk);
		goStop <= 1'b0;
		goWait <= 1'b0;
	endtask : enter

	task automatic waitWake(input logic [81:0] s, input logic expWake);
		logic woke;
		@(posedge sys_clk);
		irqSrc <= s;
		woke = 1'b0;
		repeat (10) begin
			@(posedge sys_clk);
			if (waitMode === 1'b0 && stopMode === 1'b0) woke = 1'b1;
		end
		check(woke, expWake);
	endtask : waitWake

	initial begin
		#200000;
		miscompares++;
		conclude();
	end

	initial begin
		logic [95:0] t;
		logic [81:0] s;
		repeat (2) @(posedge sys_clk);
		#1;
		check(vectorAddr, RST_ADDR);
		check(initFetch, 1'b1);
		@(posedge sys_clk);
		resetn <= 1'b1;
		for (int r = 0; r < 10; r++) begin
			bus(1'b0, r, 16'h0000, 4'hf, q);
			check(q, 32'h00000000);
		end
		bus(1'b0, 31, 16'h0000, 4'hf, q);
		check(q, 32'h00000000);
		for (int r = 0; r < 10; r++) begin
			bus(1'b1, r, rnd16(), 4'hf, q);
			bus(1'b0, r, 16'h0000, 4'hf, q);
			check(q, {16'h0000, regVal(r)});
		end
		bus(1'b1, 10, rnd16(), 4'hf, q);
		bus(1'b1, 10, 16'h3fff, 4'hc, q);
		bus(1'b0, 10, 16'h0000, 4'hf, q);
		check(q, {18'h0, vb});
		bus(1'b1, 11, 16'h001e, 4'hf, q);
		bus(1'b1, 14, 16'h001f, 4'hf, q);
		for (int r = 12; r < 17; r++) if (r != 14) bus(1'b1, r, rnd16(), 4'hf, q);
		setField(30, 2);
		setField(31, 2);
		apply(82'h1 << 30, 2'h2);
		apply(82'h1 << 31, 2'h1);
		apply(82'h3 << 30, 2'h0);
		// sources 30 and 31 sit in the second pending word, bits 14 and 15
		bus(1'b0, 18, 16'h0000, 4'hf, q);
		check(q, 32'h0000c000);
		for (int i = 0; i < 40; i++) begin
			for (int k = 0; k < 6; k++) t[k*16+:16] = rnd16() & rnd16() & rnd16();
			s = t[81:0];
			s[9:8] = 2'h0;
			if (i % 8 != 0) s[1:0] = 2'h0;
			if (i % 10 == 5) bus(1'b1, i % 10, rnd16(), 4'hf, q);
			apply(s, 2'(rnd16()));
		end
		apply(82'h0, 2'h0);
		setField(20, 1);
		setField(10, 1);
		setField(8, 1);
		setField(40, 0);
		enter(1'b0);
		setField(40, 1);
		waitWake(82'h1 << 40, 1'b0);
		waitWake(82'h1 << 20, 1'b1);
		irqSrc <= 82'h0;
		enter(1'b1);
		waitWake(82'h1 << 20, 1'b0);
		waitWake(82'h1 << 10, 1'b1);
		irqSrc <= 82'h0;
		bus(1'b1, 29, 16'h0001, 4'hf, q);
		extReqAN <= 1'b0;
		repeat (5) @(posedge sys_clk);
		// edge mode A, level 1 winner (code 10), latch A set, request up
		bus(1'b0, 29, 16'h0000, 4'hf, q);
		check(q, 32'h00000161);
		// drop the latched edge so only the level can wake from stop
		bus(1'b1, 29, 16'h0005, 4'hf, q);
		enter(1'b1);
		waitWake(82'h0, 1'b1);
		extReqAN <= 1'b1;
		conclude();
	end
endmodule : pia_arbiter_bench
